// ---- rtl/src_accum.sv ----
// accumulator for one delay tap: counts sysref hits over all windows of the tap
`timescale 1ns/1ps
module src_accum
(
    input  wire logic        clk_sys,   // device clock
    input  wire logic        rst,       // sync reset, active high
    input  wire logic        start,     // pulse: begin a new tap
    input  wire logic [1:0]  acc_code,  // accumulation length select
    input  wire logic [1:0]  avg_code,  // averaging select
    input  wire logic        sysref_in, // sampled sysref
    output logic             tap_done,  // pulse: tap measured
    output logic [15:0]      tap_score, // hits over the tap
    output logic             too_long   // sysref period over limit
);
    // ==========================================================
    // counters
    logic [8:0]  win_reg;    // cycles left in this accumulation
    logic [8:0]  avg_reg;    // accumulations left for this tap
    logic [15:0] gap_reg;    // cycles since last sysref edge
    logic        sref_q_reg; // sysref delayed for edge detect
    logic        busy_reg;   // tap measurement running
    logic [15:0] limit;      // period limit for current code

    // 4^code scaled base minus one, used for both length fields
    function automatic logic [8:0] pow4(input logic [8:0] base,
                                        input logic [1:0] code);
        pow4 = 9'((base << (2 * code)) - 9'h001);
    endfunction

    // period limit lookup
    always_comb
    begin
        unique case (acc_code)
            2'h0: limit = src_pkg::PERIOD_MAX0;
            2'h1: limit = src_pkg::PERIOD_MAX1;
            2'h2: limit = src_pkg::PERIOD_MAX2;
            2'h3: limit = src_pkg::PERIOD_MAX3;
        endcase
    end

    // ==========================================================
    // window and average counting; 256 overflows 8 bits so the
    // count is kept as length minus one
    always_ff @(posedge clk_sys)
    begin
        if (rst || start)
        begin
            win_reg   <= pow4(src_pkg::ACC_BASE, acc_code);
            avg_reg   <= pow4(src_pkg::AVG_BASE, avg_code);
            busy_reg  <= start && !rst;
            tap_done  <= 1'b0;
            tap_score <= 16'h0000;
        end
        else if (busy_reg)
        begin
            tap_done <= 1'b0;
            if (sysref_in)
                tap_score <= tap_score + 16'h0001;
            if (win_reg != 9'h000)
                win_reg <= win_reg - 9'h001;
            else if (avg_reg != 9'h000)
            begin
                // next accumulation
                win_reg <= pow4(src_pkg::ACC_BASE, acc_code);
                avg_reg <= avg_reg - 9'h001;
            end
            else
            begin
                busy_reg <= 1'b0;
                tap_done <= 1'b1;
            end
        end
        else
            tap_done <= 1'b0;
    end

    // ==========================================================
    // sysref period watchdog: too long a gap fails the cal; the gap
    // spans tap boundaries, since at averaging code 0 a tap is far shorter than the longest
    // legal period and a per-tap restart would hide a slow sysref
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            gap_reg    <= 16'h0000;
            sref_q_reg <= 1'b0;
            too_long   <= 1'b0;
        end
        else
        begin
            sref_q_reg <= sysref_in;
            if (sysref_in && !sref_q_reg)
                gap_reg <= 16'h0000;
            else if (gap_reg != 16'hffff)
                gap_reg <= gap_reg + 16'h0001;
            if (busy_reg && gap_reg > limit)
                too_long <= 1'b1;
        end
    end
endmodule // src_accum

// ---- rtl/src_cal.sv ----
// top: sysref timing calibration control with 8-bit register port
`timescale 1ns/1ps
// Function
// - enable low: delay output follows manual register
// - enable high: delay found automatically, manual ignored
// - rising enable starts a new sequence
// - averaging code selects 4/16/64/256 averages
// - accumulation code selects 4/16/64/256 cycles
// - sysref period over limit fails calibration
// - calibration ends within 384*19*4^(avg+acc+2) cycles
// - config resets to 0x05, enable to zero
// - done flag only when enabled and finished
// - status reports 17-bit inversion/coarse/fine delay
module src_cal
(
    input  wire logic        clk_sys,      // device clock
    input  wire logic        rst,          // sync reset, active high
    input  wire logic        reg_wr,       // register write strobe
    input  wire logic        reg_rd,       // register read strobe
    input  wire logic [11:0] reg_addr,     // register address
    input  wire logic [7:0]  reg_wdata,    // write data
    input  wire logic        sysref_in,    // sampled sysref
    output logic [7:0]       reg_rdata,    // read data, next cycle
    output logic [16:0]      delay_out,    // applied clock delay
    output logic             cal_complete_flag // done, enabled
);
    // ==========================================================
    // registers
    logic [7:0]  sysref_cal_enable_reg; // enable + reserved
    logic [7:0]  sysref_cal_config;     // avg/acc + reserved
    logic [23:0] tad_manual_reg;        // manual delay + reserved
    logic [16:0] computed_delay_result; // best tap found
    logic        done_reg;              // sequence finished
    logic [15:0] best_score_reg;        // best tap score so far
    logic [8:0]  tap_reg;               // tap under test
    logic        enable_q_reg;          // enable for edge detect
    logic        tap_start_reg;         // pulse to accumulator
    src_pkg::src_state_type state_reg;  // sequencer state
    logic        tap_done;              // accumulator tap finished
    logic [15:0] tap_score;             // accumulator result
    logic        too_long;              // sysref period fault
    logic        enable_bit;            // calibration enable
    logic        rise;                  // 0-to-1 of enable
    logic        accum_clear;           // accumulator clear, per sequence
    logic [23:0] status_word;           // assembled status

    assign enable_bit  = sysref_cal_enable_reg[src_pkg::ENABLE_BIT];
    assign rise        = enable_bit && !enable_q_reg;
    // a new sequence also restarts the sysref watchdog, so a stale gap
    // from before enable cannot fail the first tap
    assign accum_clear = rst || rise;
    assign status_word = {6'h00, cal_complete_flag, computed_delay_result};

    // ==========================================================
    // register writes; all bits stored, reserved ones unused
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            sysref_cal_enable_reg <= src_pkg::ENABLE_RESET;
            sysref_cal_config     <= src_pkg::CONFIG_RESET;
            tad_manual_reg        <= src_pkg::TAD_RESET;
        end
        else if (reg_wr)
        begin
            unique case (reg_addr)
                src_pkg::ADDR_ENABLE: sysref_cal_enable_reg <= reg_wdata;
                src_pkg::ADDR_CONFIG: sysref_cal_config <= reg_wdata;
                src_pkg::ADDR_TAD_LO: tad_manual_reg[7:0]   <= reg_wdata;
                src_pkg::ADDR_TAD_MI: tad_manual_reg[15:8]  <= reg_wdata;
                src_pkg::ADDR_TAD_HI: tad_manual_reg[23:16] <= reg_wdata;
                default: ; // unmapped or read-only: write dropped
            endcase
        end
    end

    // ==========================================================
    // read port, one cycle latency; unmapped reads as zero
    always_ff @(posedge clk_sys)
    begin
        if (rst)
            reg_rdata <= 8'h00;
        else if (reg_rd)
        begin
            unique case (reg_addr)
                src_pkg::ADDR_ENABLE:    reg_rdata <= sysref_cal_enable_reg;
                src_pkg::ADDR_CONFIG:    reg_rdata <= sysref_cal_config;
                src_pkg::ADDR_STATUS_LO: reg_rdata <= status_word[7:0];
                src_pkg::ADDR_STATUS_MI: reg_rdata <= status_word[15:8];
                src_pkg::ADDR_STATUS_HI: reg_rdata <= status_word[23:16];
                src_pkg::ADDR_TAD_LO:    reg_rdata <= tad_manual_reg[7:0];
                src_pkg::ADDR_TAD_MI:    reg_rdata <= tad_manual_reg[15:8];
                src_pkg::ADDR_TAD_HI:    reg_rdata <= tad_manual_reg[23:16];
                default:                 reg_rdata <= 8'h00;
            endcase
        end
    end

    // ==========================================================
    // sequencer: sweep taps, keep best score; a rising enable
    // always restarts, clearing the done state
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            state_reg             <= src_pkg::SRC_IDLE;
            enable_q_reg          <= 1'b0;
            tap_start_reg         <= 1'b0;
            tap_reg               <= 9'h000;
            best_score_reg        <= 16'h0000;
            computed_delay_result <= 17'h00000;
            done_reg              <= 1'b0;
        end
        else
        begin
            enable_q_reg  <= enable_bit;
            tap_start_reg <= 1'b0;
            if (!enable_bit)
            begin
                state_reg <= src_pkg::SRC_IDLE;
                done_reg  <= 1'b0;
            end
            else if (rise)
            begin
                state_reg      <= src_pkg::SRC_SWEEP;
                tap_reg        <= 9'h000;
                best_score_reg <= 16'h0000;
                done_reg       <= 1'b0;
                tap_start_reg  <= 1'b1;
            end
            else
            begin
                unique case (state_reg)
                    src_pkg::SRC_IDLE: ;
                    src_pkg::SRC_SWEEP:
                    begin
                        if (too_long)
                            state_reg <= src_pkg::SRC_FAIL;
                        else if (tap_done)
                        begin
                            // pick the tap landing closest to sysref
                            if (tap_score >= best_score_reg)
                            begin
                                best_score_reg <= tap_score;
                                computed_delay_result <=
                                    {tap_reg[8], tap_reg[7:0], 8'h00};
                            end
                            if (tap_reg == src_pkg::TAP_COUNT - 9'h001)
                            begin
                                state_reg <= src_pkg::SRC_FINISH;
                                done_reg  <= 1'b1;
                            end
                            else
                            begin
                                tap_reg       <= tap_reg + 9'h001;
                                tap_start_reg <= 1'b1;
                            end
                        end
                    end
                    src_pkg::SRC_FINISH: ; // hold result
                    src_pkg::SRC_FAIL: ;    // done stays low
                    default: state_reg <= src_pkg::SRC_IDLE;
                endcase
            end
        end
    end

    // ==========================================================
    // outputs straight from flops
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            delay_out         <= 17'h00000;
            cal_complete_flag <= 1'b0;
        end
        else
        begin
            cal_complete_flag <= done_reg && enable_bit;
            if (!enable_bit)
                delay_out <= tad_manual_reg[16:0];
            else if (done_reg)
                delay_out <= computed_delay_result;
        end
    end

    // tap measurement engine
    src_accum u_accum
    (
        .clk_sys   (clk_sys),
        .rst       (accum_clear),
        .start     (tap_start_reg),
        .acc_code  (sysref_cal_config[src_pkg::ACC_LSB +: 2]),
        .avg_code  (sysref_cal_config[src_pkg::AVG_LSB +: 2]),
        .sysref_in (sysref_in),
        .tap_done  (tap_done),
        .tap_score (tap_score),
        .too_long  (too_long)
    );

    // ==========================================================
    // checks
    property p_manual;
        @(posedge clk_sys) disable iff (rst)
        !enable_bit |=> delay_out == $past(tad_manual_reg[16:0]);
    endproperty
    a_manual: assert property (p_manual) else $error("manual delay");

    property p_hold;
        @(posedge clk_sys) disable iff (rst)
        (enable_bit && !done_reg && $past(enable_bit))
            |=> $stable(delay_out);
    endproperty
    a_hold: assert property (p_hold) else $error("delay moved");

    property p_restart;
        @(posedge clk_sys) disable iff (rst)
        rise |=> state_reg == src_pkg::SRC_SWEEP && !done_reg;
    endproperty
    a_restart: assert property (p_restart) else $error("no restart");

    property p_done;
        @(posedge clk_sys) disable iff (rst)
        cal_complete_flag |-> $past(enable_bit) && $past(done_reg);
    endproperty
    a_done: assert property (p_done) else $error("bad done");

    property p_reset;
        @(posedge clk_sys) rst |=> sysref_cal_config == 8'h05
            && sysref_cal_enable_reg == 8'h00;
    endproperty
    a_reset: assert property (p_reset) else $error("reset value");

    property p_apply;
        @(posedge clk_sys) disable iff (rst)
        (enable_bit && done_reg) ##1 enable_bit
            |-> delay_out == $past(computed_delay_result);
    endproperty
    a_apply: assert property (p_apply) else $error("not applied");
endmodule // src_cal

// ---- rtl/src_pkg.sv ----
// package: register map, field layout and timing constants for sysref cal
package src_pkg;
    // ==========================================================
    // register offsets (8-bit register port, byte addresses)
    localparam logic [11:0] ADDR_ENABLE    = 12'h2b0; // enable register
    localparam logic [11:0] ADDR_CONFIG    = 12'h2b1; // configuration
    localparam logic [11:0] ADDR_STATUS_LO = 12'h2b2; // status [7:0]
    localparam logic [11:0] ADDR_STATUS_MI = 12'h2b3; // status [15:8]
    localparam logic [11:0] ADDR_STATUS_HI = 12'h2b4; // status [23:16]
    localparam logic [11:0] ADDR_TAD_LO    = 12'h2b5; // manual delay [7:0]
    localparam logic [11:0] ADDR_TAD_MI    = 12'h2b6; // manual delay [15:8]
    localparam logic [11:0] ADDR_TAD_HI    = 12'h2b7; // manual delay [23:16]
    // ==========================================================
    // reset values and field positions
    localparam logic [7:0]  ENABLE_RESET   = 8'h00;
    localparam logic [7:0]  CONFIG_RESET   = 8'h05;
    localparam logic [23:0] TAD_RESET      = 24'h000000;
    localparam int          ENABLE_BIT     = 0;
    localparam int          AVG_LSB        = 2;
    localparam int          ACC_LSB        = 0;
    localparam int          DONE_BIT       = 17;
    localparam int          DELAY_W        = 17;
    // ==========================================================
    // timing: bound on cal duration is 384*19*4^(avg+acc+2) cycles
    localparam int          CAL_BOUND_K    = 384 * 19;
    localparam logic [8:0]  ACC_BASE       = 9'h004; // 4 cycles, code 0
    localparam logic [8:0]  AVG_BASE       = 9'h004; // 4 averages, code 0
    // longest legal sysref period per accumulation code
    localparam logic [15:0] PERIOD_MAX0    = 16'd128;
    localparam logic [15:0] PERIOD_MAX1    = 16'd1664;
    localparam logic [15:0] PERIOD_MAX2    = 16'd7808;
    localparam logic [15:0] PERIOD_MAX3    = 16'd32384;
    // number of delay taps swept per calibration
    localparam logic [8:0]  TAP_COUNT      = 9'h180;
    // calibration state machine, one-hot
    typedef enum logic [3:0]
    {
        SRC_IDLE  = 4'b0001,
        SRC_SWEEP = 4'b0010,
        SRC_FINISH = 4'b0100,
        SRC_FAIL  = 4'b1000
    } src_state_type;
endpackage

// ---- verification/src_sysref_model.sv ----
// partner model: periodic sysref source seen by the calibration block
`timescale 1ns/1ps
module src_sysref_model
(
    input  wire logic        clk_sys,   // device clock
    input  wire logic        run,       // pulses only while high
    input  wire logic [15:0] period,    // cycles from pulse to pulse
    output logic             sysref_in  // one-cycle pulse, idle low
);
    logic [15:0] count_reg;             // cycles since the last pulse
    // ==========================================================
    // pulse generator
    // the bench keeps the period within the limit of the chosen
    // accumulation code, except in the run that must fail
    always_ff @(posedge clk_sys)
    begin
        if (!run)
        begin
            // stopped source: line rests low, count restarts
            count_reg <= 16'h0000;
            sysref_in <= 1'b0;
        end
        else if (count_reg >= period - 16'h0001)
        begin
            count_reg <= 16'h0000;
            sysref_in <= 1'b1;
        end
        else
        begin
            count_reg <= count_reg + 16'h0001;
            sysref_in <= 1'b0;
        end
    end
endmodule // src_sysref_model

// ---- verification/sysref_timing_calibration_tb_top.sv ----
// testbench: registers, manual delay and sysref calibration runs
`timescale 1ns/1ps
module sysref_timing_calibration_tb_top;
    logic        clk_sys;           // device clock
    logic        rst;               // sync reset
    logic        reg_wr;            // write strobe
    logic        reg_rd;            // read strobe
    logic [11:0] reg_addr;          // register address
    logic [7:0]  reg_wdata;         // write data
    logic        sysref_in;         // from the source model
    logic [7:0]  reg_rdata;         // read data
    logic [16:0] delay_out;         // applied delay
    logic        cal_complete_flag; // done flag
    logic        sr_run;            // source running
    logic [15:0] sr_period;         // source period
    logic [16:0] manual;            // expected manual delay
    int          miscompares;       // mismatches
    int          check_count;       // comparisons made
    int          cycles;            // timeout counter
    src_cal i_src_cal (.clk_sys(clk_sys), .rst(rst), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .sysref_in(sysref_in), .reg_rdata(reg_rdata),
        .delay_out(delay_out), .cal_complete_flag(cal_complete_flag));
    src_sysref_model i_src_sysref_model (.clk_sys(clk_sys), .run(sr_run),
        .period(sr_period), .sysref_in(sysref_in));
    // ==========================================================
    // clock and hang guard; ceiling covers the three long runs
    initial
    begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys)
    begin
        cycles++;
        if (cycles == 90000)
        begin
            miscompares++;
            conclude();
        end
    end
    // ==========================================================
    // shared helpers
    task automatic conclude();
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic chk(input string name, input logic [23:0] exp,
                       input logic [23:0] got);
        check_count++;
        if (got !== exp)
        begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask
    // one-cycle strobe, raised and lowered on falling edges
    task automatic wr_reg(input logic [11:0] a, input logic [7:0] d);
        @(negedge clk_sys);
        reg_wr = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        @(negedge clk_sys);
        reg_wr = 1'b0;
    endtask
    task automatic rd_reg(input logic [11:0] a, output logic [7:0] d);
        @(negedge clk_sys);
        reg_rd = 1'b1;
        reg_addr = a;
        @(negedge clk_sys);
        reg_rd = 1'b0;
        @(negedge clk_sys);
        d = reg_rdata;
    endtask
    task automatic wait_flag(input int limit, output logic seen);
        int n;
        seen = 1'b0;
        for (n = 0; n < limit && seen !== 1'b1; n++)
        begin
            @(negedge clk_sys);
            seen = (cal_complete_flag === 1'b1);
        end
    endtask
    // ==========================================================
    // scenarios
    task automatic test_reset();
        logic [7:0] d;
        rd_reg(src_pkg::ADDR_CONFIG, d);
        chk("config", 24'h000005, {16'h0000, d});
        rd_reg(src_pkg::ADDR_ENABLE, d);
        chk("enable", 24'h000000, {16'h0000, d});
        chk("flag", 24'h000000, {23'h000000, cal_complete_flag});
        chk("delay", 24'h000000, {7'h00, delay_out});
    endtask
    task automatic test_manual();
        logic [7:0] d;
        wr_reg(src_pkg::ADDR_TAD_LO, 8'h34);
        wr_reg(src_pkg::ADDR_TAD_MI, 8'h12);
        wr_reg(src_pkg::ADDR_TAD_HI, 8'h01);
        manual = 17'h11234;
        repeat (2) @(negedge clk_sys);
        chk("manual delay", {7'h00, manual}, {7'h00, delay_out});
        rd_reg(src_pkg::ADDR_TAD_HI, d);
        chk("manual hi", 24'h000001, {16'h0000, d});
        wr_reg(src_pkg::ADDR_CONFIG, 8'hf0);
        rd_reg(src_pkg::ADDR_CONFIG, d);
        chk("config rsvd", 24'h0000f0, {16'h0000, d});
        wr_reg(src_pkg::ADDR_ENABLE, 8'hfe);
        rd_reg(src_pkg::ADDR_ENABLE, d);
        chk("enable rsvd", 24'h0000fe, {16'h0000, d});
        chk("rsvd flag", 24'h000000, {23'h000000, cal_complete_flag});
        chk("rsvd delay", {7'h00, manual}, {7'h00, delay_out});
        rd_reg(12'h2b8, d);
        chk("unmapped", 24'h000000, {16'h0000, d});
        wr_reg(src_pkg::ADDR_ENABLE, 8'h00);
    endtask
    // one calibration run; limit is capped by the duration bound
    task automatic test_cal(input logic [7:0] cfg, input logic [15:0] per,
                            input int limit, input logic expect_done);
        logic       seen;
        logic [7:0] b0;
        logic [7:0] b1;
        logic [7:0] b2;
        int         bound;
        bound = src_pkg::CAL_BOUND_K
              * (4 ** (int'(cfg[3:2]) + int'(cfg[1:0]) + 2));
        if (bound < limit)
            limit = bound;
        sr_period = per;
        sr_run = 1'b1;
        wr_reg(src_pkg::ADDR_CONFIG, cfg);
        wr_reg(src_pkg::ADDR_ENABLE, 8'h01);
        repeat (2) @(negedge clk_sys);
        chk("flag at start", 24'h0, {23'h0, cal_complete_flag});
        wait_flag(limit, seen);
        chk("finished", {23'h0, expect_done}, {23'h0, seen});
        rd_reg(src_pkg::ADDR_STATUS_LO, b0);
        rd_reg(src_pkg::ADDR_STATUS_MI, b1);
        rd_reg(src_pkg::ADDR_STATUS_HI, b2);
        if (expect_done)
        begin
            chk("fine", 24'h0, {16'h0, delay_out[7:0]});
            chk("status", {6'h00, 1'b1, delay_out}, {b2, b1, b0});
            b0 = delay_out[7:0];
            wr_reg(src_pkg::ADDR_TAD_LO, 8'haa);
            manual[7:0] = 8'haa;
            repeat (2) @(negedge clk_sys);
            chk("held", {16'h0, b0}, {16'h0, delay_out[7:0]});
            chk("held flag", 24'h1, {23'h0, cal_complete_flag});
        end
        else
            chk("fail done", 24'h0, {22'h0, b2[1:0] & 2'b10});
    endtask
    task automatic test_disable();
        wr_reg(src_pkg::ADDR_ENABLE, 8'h00);
        repeat (2) @(negedge clk_sys);
        chk("off flag", 24'h0, {23'h0, cal_complete_flag});
        chk("off delay", {7'h00, manual}, {7'h00, delay_out});
    endtask
    // ==========================================================
    // main sequence
    initial
    begin
        rst = 1'b1;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 12'h000;
        reg_wdata = 8'h00;
        sr_run = 1'b0;
        sr_period = 16'h0040;
        manual = 17'h00000;
        miscompares = 0;
        check_count = 0;
        cycles = 0;
        repeat (4) @(negedge clk_sys);
        rst = 1'b0;
        test_reset();
        test_manual();
        test_cal(8'h00, 16'h0040, 30000, 1'b1);
        test_disable();
        test_cal(8'h01, 16'h03e8, 30000, 1'b1);
        test_disable();
        // period over the code-0 limit: the run must not finish
        test_cal(8'h00, 16'h03e8, 30000, 1'b0);
        conclude();
    end
endmodule // sysref_timing_calibration_tb_top
